/* File: design/pump_ctrl_regs.svh */
// Register offsets, field positions, reset values and timing figures of the pump control
`ifndef PUMP_CTRL_REGS_SVH
`define PUMP_CTRL_REGS_SVH
// Register byte addresses
`define CFG_ADDR 12'h000
`define STATUS_ADDR 12'h004
// Configuration register: soft-start ramp increment
`define CFG_RESET 8'h01
`define CFG_STEP_MSB 7
// Status register fields
`define STAT_EN_BIT 0
`define STAT_FLASH_BIT 1
`define STAT_TIMEOUT_BIT 2
`define STAT_SINKS_BIT 3
`define STAT_GAIN_LSB 4
`define STAT_GAIN_MSB 5
`define STAT_REF_LSB 8
`define STAT_REF_MSB 15
// Timing figures
`define CLK_PERIOD_NS 50
`define NS_PER_MS 1000000
`define TORCH_STEP_MS 125
`define FLASH_STEP_MS 2
`define FLASH_TIMEOUT_MS 1000
`define RAMP_TICK_NS 1000
`endif

/* File: design/pump_ctrl_pkg.sv */
// Types shared by the pump mode control design
package pump_ctrl_pkg;
   // Sequencer states
   typedef enum logic [2:0] {ST_OFF, ST_SOFTSTART, ST_WAIT_REG, ST_RUN, ST_TIMEOUT} state_e;
   // Pump gain settings, ordered so that a larger code is a larger gain
   typedef enum logic [1:0] {GAIN_1X, GAIN_1P5X, GAIN_2X} gain_e;
endpackage : pump_ctrl_pkg

/* File: design/input_sync.sv */
// Two-stage synchronisers for asynchronous pin and comparator inputs
`timescale 1ns/1ps
module input_sync #(
   parameter int WIDTH = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // One pair of flops per bit; the first flop feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_ff; // First stage, may go metastable
         logic sync_ff; // Second stage, safe to decode
         // Reset to low so a floating pin reads as off
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= async_in[i];
               sync_ff <= meta_ff;
            end
         end
         assign sync_out[i] = sync_ff;
      end
   endgenerate
endmodule : input_sync

/* File: design/soft_start_ramp.sv */
// Reference ramp generator for soft start
`timescale 1ns/1ps
module soft_start_ramp #(
   parameter int WIDTH = 8,
   parameter int TICK_CYC = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [WIDTH-1:0] step,
   output logic [WIDTH-1:0] ref_level,
   output logic ramp_done
);
   localparam logic [WIDTH-1:0] REF_MAX = '1;
   logic [15:0] div_ff; // Tick divider
   logic tick; // One-cycle enable at the ramp rate
   logic [WIDTH-1:0] ref_ff; // Present reference
   logic [WIDTH:0] sum; // Unclipped next reference

   assign tick = (div_ff == 16'(TICK_CYC - 1));
   assign sum = {1'b0, ref_ff} + {1'b0, step};

   // Divider runs only while ramping so every ramp starts from a fresh tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 16'h0000;
      end else if (!run || tick) begin
         div_ff <= 16'h0000;
      end else begin
         div_ff <= div_ff + 16'h0001;
      end
   end

   // Reference climbs in bounded steps and saturates at full scale
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_ff <= '0;
      end else if (!run) begin
         ref_ff <= '0;
      end else if (tick) begin
         ref_ff <= sum[WIDTH] ? REF_MAX : sum[WIDTH-1:0];
      end
   end

   assign ref_level = ref_ff;
   assign ramp_done = (ref_ff == REF_MAX);
endmodule : soft_start_ramp

/* File: design/flash_led_pump_mode_control.sv */
// Mode, start-up, gain and flash timeout control of the flash LED charge pump
// Operation
// - Enable low: everything off, output disconnected
// - Torch level unless flash selected, hold low
// - Transmit hold forces torch level while high
// - Sink select high disables fourth sink
// - Control inputs active high, undriven reads low
// - Gain only steps upward while enabled
// - Step takes 125ms torch, 2ms flash
// - Reached gain held while enable stays high
// - Re-enable restarts from lowest gain
// - Raise gain when sinks lose regulation
// - Sinks turn on after output reaches regulation
// - Soft start ramps reference, limits inrush
// - Flash select over 1s: sinks off
// - Timeout holds until enable goes low
// - Timeout timer paused during transmit hold
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "pump_ctrl_regs.svh"
module flash_led_pump_mode_control
   import pump_ctrl_pkg::*;
#(
   parameter int TORCH_STEP_CYC = `TORCH_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS,
   parameter int FLASH_STEP_CYC = `FLASH_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS,
   parameter int TIMEOUT_CYC = `FLASH_TIMEOUT_MS * `NS_PER_MS / `CLK_PERIOD_NS,
   parameter int CNT_W = 25,
   parameter int REF_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control pins
   input wire logic master_enable,
   input wire logic torch_flash_select,
   input wire logic pa_transmit_hold,
   input wire logic sink_count_select,
   // Analog monitors
   input wire logic output_in_regulation,
   input wire logic sink_out_of_regulation,
   // Analog controls
   output logic pump_enable,
   output logic pump_output_connect,
   output logic [1:0] pump_gain,
   output logic [REF_W-1:0] reference_level,
   output logic flash_level_select,
   output logic [3:0] sink_enable,
   output logic timeout_active
);
   localparam int TICK_CYC = `RAMP_TICK_NS / `CLK_PERIOD_NS;

   // Synchronised inputs
   logic [5:0] sync_w;
   logic en_s; // Master enable
   logic tf_s; // Torch/flash select
   logic tx_s; // Transmit hold
   logic sel_s; // Three-sink select
   logic reg_s; // Pump output in regulation
   logic oor_s; // Sinks out of regulation

   // Sequencer and control state
   state_e state_ff;
   state_e nxt_state;
   gain_e gain_ff;
   logic [CNT_W-1:0] step_cnt_ff; // Out-of-regulation persistence count
   logic [CNT_W-1:0] to_cnt_ff; // Flash on-time count
   logic [CNT_W-1:0] step_lim; // Persistence needed for a step
   logic flash_act; // Flash level demanded
   logic step_hit; // Gain step due this cycle
   logic to_hit; // Flash timeout reached this cycle
   logic ramp_run; // Soft start ramp running
   logic ramp_done; // Ramp at full scale
   logic [REF_W-1:0] ref_w; // Ramp output
   logic [7:0] cfg_step_ff; // Software ramp increment
   logic [31:0] status_w; // Status word
   logic [31:0] prdata_ff; // Read data latched in setup
   logic addr_ok; // Mapped address

   // Every pin and comparator is asynchronous to pclk
   input_sync #(
      .WIDTH(6)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({sink_out_of_regulation, output_in_regulation, sink_count_select,
                 pa_transmit_hold, torch_flash_select, master_enable}),
      .sync_out(sync_w)
   );

   // Synchroniser resets low, so an undriven pin decodes as off
   assign en_s = sync_w[0];
   assign tf_s = sync_w[1];
   assign tx_s = sync_w[2];
   assign sel_s = sync_w[3];
   assign reg_s = sync_w[4];
   assign oor_s = sync_w[5];

   // Flash level needs flash select and no transmit hold
   assign flash_act = tf_s && !tx_s;

   // Persistence limit follows the present current level
   assign step_lim = flash_act ? CNT_W'(FLASH_STEP_CYC - 1) :
                                 CNT_W'(TORCH_STEP_CYC - 1);

   // A step is due once the fault has lasted the whole limit
   assign step_hit = (state_ff != ST_OFF) && oor_s && (gain_ff != GAIN_2X) &&
                     (step_cnt_ff >= step_lim);

   // Timeout trips only while flash level runs with sinks on
   assign to_hit = (state_ff == ST_RUN) && flash_act &&
                   (to_cnt_ff == CNT_W'(TIMEOUT_CYC - 1));

   // Ramp runs from enable until enable drops, through run and timeout as well
   assign ramp_run = (state_ff != ST_OFF);

   // Soft start reference ramp
   soft_start_ramp #(
      .WIDTH(REF_W),
      .TICK_CYC(TICK_CYC)
   ) u_ramp (
      .pclk(pclk),
      .presetn(presetn),
      .run(ramp_run),
      .step(cfg_step_ff[REF_W-1:0]),
      .ref_level(ref_w),
      .ramp_done(ramp_done)
   );

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         // Wait for enable
         ST_OFF: begin
            if (en_s) begin
               nxt_state = ST_SOFTSTART;
            end
         end
         // Reference ramping, sinks still off
         ST_SOFTSTART: begin
            if (ramp_done) begin
               nxt_state = ST_WAIT_REG;
            end
         end
         // Pump running, wait for output regulation
         ST_WAIT_REG: begin
            if (reg_s) begin
               nxt_state = ST_RUN;
            end
         end
         // Normal operation
         ST_RUN: begin
            if (to_hit) begin
               nxt_state = ST_TIMEOUT;
            end
         end
         // Latched until enable drops
         ST_TIMEOUT: begin
            nxt_state = ST_TIMEOUT;
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
      // Enable low overrides every state
      if (!en_s) begin
         nxt_state = ST_OFF;
      end
   end

   // Sequencer state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Persistence counter restarts whenever the fault clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt_ff <= '0;
      end else if (state_ff == ST_OFF || !oor_s || step_hit) begin
         step_cnt_ff <= '0;
      end else if (gain_ff != GAIN_2X) begin
         step_cnt_ff <= step_cnt_ff + CNT_W'(1);
      end
   end

   // Gain only climbs; shutdown is the only way back to 1x
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_ff <= GAIN_1X;
      end else if (state_ff == ST_OFF) begin
         gain_ff <= GAIN_1X;
      end else if (step_hit) begin
         // One step per full persistence interval
         gain_ff <= (gain_ff == GAIN_1X) ? GAIN_1P5X : GAIN_2X;
      end
      // Otherwise the reached gain is held
   end

   // Flash on-time: cleared by torch, frozen by transmit hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_cnt_ff <= '0;
      end else if (state_ff != ST_RUN || !tf_s) begin
         to_cnt_ff <= '0;
      end else if (tx_s) begin
         to_cnt_ff <= to_cnt_ff;
      end else if (!to_hit) begin
         to_cnt_ff <= to_cnt_ff + CNT_W'(1);
      end
   end

   // Pump and output switch follow the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_enable <= 1'b0;
         pump_output_connect <= 1'b0;
         timeout_active <= 1'b0;
      end else begin
         // Pump stays up in timeout so the output keeps its charge
         pump_enable <= (state_ff != ST_OFF);
         pump_output_connect <= (state_ff != ST_OFF);
         timeout_active <= (state_ff == ST_TIMEOUT);
      end
   end

   // Sinks conduct only in run; fourth one obeys the select pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sink_enable <= 4'h0;
      end else if (state_ff == ST_RUN) begin
         sink_enable <= {!sel_s, 3'h7};
      end else begin
         sink_enable <= 4'h0;
      end
   end

   // Current level and analog gain code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_level_select <= 1'b0;
         pump_gain <= 2'h0;
         reference_level <= '0;
      end else begin
         flash_level_select <= flash_act && (state_ff != ST_OFF);
         pump_gain <= gain_ff;
         reference_level <= ref_w;
      end
   end

   // APB: zero wait states, read data captured in setup
   assign addr_ok = (paddr == `CFG_ADDR) || (paddr == `STATUS_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = prdata_ff;

   // Status word assembly; unused bits read zero
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[`STAT_EN_BIT] = (state_ff != ST_OFF);
      status_w[`STAT_FLASH_BIT] = flash_level_select;
      status_w[`STAT_TIMEOUT_BIT] = (state_ff == ST_TIMEOUT);
      status_w[`STAT_SINKS_BIT] = (state_ff == ST_RUN);
      status_w[`STAT_GAIN_MSB:`STAT_GAIN_LSB] = gain_ff;
      status_w[`STAT_REF_MSB:`STAT_REF_LSB] = ref_w;
   end

   // Configuration write in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_step_ff <= `CFG_RESET;
      end else if (psel && penable && pwrite && paddr == `CFG_ADDR) begin
         cfg_step_ff <= pwdata[`CFG_STEP_MSB:0];
      end
   end

   // Read data latched in setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `CFG_ADDR) begin
            prdata_ff <= {24'h000000, cfg_step_ff};
         end else if (paddr == `STATUS_ADDR) begin
            prdata_ff <= status_w;
         end else begin
            prdata_ff <= 32'h0000_0000; // Unmapped reads zero
         end
      end
   end

   // Checks on the control behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   shutdown_off_a: assert property (
      state_ff == ST_OFF |=> sink_enable == 4'h0 && !pump_enable && !pump_output_connect)
      else $error("outputs active in shutdown");

   flash_level_a: assert property (
      state_ff != ST_OFF && tf_s && !tx_s |=> flash_level_select)
      else $error("flash level not selected");

   tx_torch_a: assert property (
      tx_s |=> !flash_level_select)
      else $error("flash level during transmit hold");

   sink_select_a: assert property (
      state_ff == ST_RUN && sel_s |=> sink_enable == 4'h7)
      else $error("fourth sink not disabled");

   gain_monotonic_a: assert property (
      $past(state_ff) != ST_OFF && state_ff != ST_OFF |-> gain_ff >= $past(gain_ff))
      else $error("gain stepped down while enabled");

   step_time_a: assert property (
      gain_ff != $past(gain_ff) && $past(state_ff) != ST_OFF
      |-> $past(step_cnt_ff) == $past(step_lim) && $past(oor_s))
      else $error("gain step before persistence time");

   gain_restart_a: assert property (
      state_ff == ST_OFF |=> gain_ff == GAIN_1X)
      else $error("gain not cleared by shutdown");

   sinks_after_reg_a: assert property (
      state_ff == ST_WAIT_REG ##1 state_ff == ST_RUN |-> $past(reg_s) ##1 sink_enable != 4'h0)
      else $error("sinks not gated by regulation");

   ramp_bounded_a: assert property (
      state_ff != ST_OFF && $past(state_ff) != ST_OFF
      |-> {1'b0, ref_w} <= {1'b0, $past(ref_w)} + {1'b0, cfg_step_ff})
      else $error("reference stepped too far");

   timeout_hold_a: assert property (
      state_ff == ST_TIMEOUT && en_s |=> state_ff == ST_TIMEOUT ##1 sink_enable == 4'h0 && pump_enable)
      else $error("timeout state not held");

   timer_pause_a: assert property (
      state_ff == ST_RUN && tf_s && tx_s && !to_hit |=> to_cnt_ff == $past(to_cnt_ff))
      else $error("timeout timer ran in transmit hold");

   flash_run_c: cover property (state_ff == ST_RUN && flash_act);
   tx_in_flash_c: cover property (state_ff == ST_RUN && tf_s && tx_s);
   gain_top_c: cover property (gain_ff == GAIN_2X);
   timeout_c: cover property (state_ff == ST_RUN ##1 state_ff == ST_TIMEOUT);
endmodule : flash_led_pump_mode_control

/* File: sim/pump_host_model.sv */
// Host processor and RF power amplifier timing model that drives the four control pins
`timescale 1ns/1ps
module pump_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en_req,
   input wire logic flash_req,
   input wire logic sel_req,
   input wire logic tx_start,
   input wire logic [7:0] tx_len,
   output logic master_enable,
   output logic torch_flash_select,
   output logic pa_transmit_hold,
   output logic sink_count_select
);
   logic supply_ok_ff; // Supply seen powered
   logic [7:0] tx_cnt_ff; // Cycles left in the transmit pulse
   // Pins rest low like the pull-downs; enable waits until the supply is up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_ok_ff <= 1'b0;
         master_enable <= 1'b0;
         torch_flash_select <= 1'b0;
         sink_count_select <= 1'b0;
      end else begin
         supply_ok_ff <= 1'b1;
         master_enable <= en_req & supply_ok_ff;
         torch_flash_select <= flash_req;
         sink_count_select <= sel_req;
      end
   end
   // Transmit pulse lasts exactly tx_len cycles, then the pin drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_ff <= 8'h00;
      end else if (tx_start) begin
         tx_cnt_ff <= tx_len;
      end else if (tx_cnt_ff != 8'h00) begin
         tx_cnt_ff <= tx_cnt_ff - 8'h01;
      end
   end
   assign pa_transmit_hold = (tx_cnt_ff != 8'h00);
endmodule : pump_host_model

/* File: sim/flash_led_pump_mode_control_tb.sv */
// Self-checking testbench for the flash LED pump mode control
`timescale 1ns/1ps
module flash_led_pump_mode_control_tb;
   localparam int FS = 10; // Shortened flash step
   localparam int TS = 50; // Shortened torch step
   localparam int TO = 200; // Shortened flash timeout
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, master_enable, torch_flash_select, pa_transmit_hold;
   logic sink_count_select, pump_enable, pump_output_connect, flash_level_select;
   logic timeout_active, output_in_regulation = 0, sink_out_of_regulation = 0;
   logic [1:0] pump_gain, gain_tgt = 0;
   logic [7:0] reference_level, tx_len = 0, lfsr = 8'h60, step;
   logic [3:0] sink_enable;
   logic en_req = 0, flash_req = 0, sel_req = 0, tx_start = 0;
   logic sinks_on, ref_on, gain_hit;
   logic [32:0] rd_q[$]; // Expected {pslverr, prdata}
   logic [19:0] out_q[$], w; // Expected {mask, outputs}
   int num_errors = 0, num_checks = 0, n;
   always #25 pclk = ~pclk;
   always_comb begin
      sinks_on = |sink_enable;
      ref_on = |reference_level;
      gain_hit = (pump_gain === gain_tgt);
   end
   pump_host_model host (.pclk(pclk), .presetn(presetn), .en_req(en_req),
      .flash_req(flash_req), .sel_req(sel_req), .tx_start(tx_start), .tx_len(tx_len),
      .master_enable(master_enable), .torch_flash_select(torch_flash_select),
      .pa_transmit_hold(pa_transmit_hold), .sink_count_select(sink_count_select));
   flash_led_pump_mode_control #(.TORCH_STEP_CYC(TS), .FLASH_STEP_CYC(FS), .TIMEOUT_CYC(TO)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .master_enable(master_enable), .torch_flash_select(torch_flash_select),
      .pa_transmit_hold(pa_transmit_hold), .sink_count_select(sink_count_select),
      .output_in_regulation(output_in_regulation),
      .sink_out_of_regulation(sink_out_of_regulation), .pump_enable(pump_enable),
      .pump_output_connect(pump_output_connect), .pump_gain(pump_gain),
      .reference_level(reference_level), .flash_level_select(flash_level_select),
      .sink_enable(sink_enable), .timeout_active(timeout_active));
   // Eight-bit shift register for the pseudo-random ramp step
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next
   task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task summarize;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task tick(input int k);
      repeat (k) @(posedge pclk);
   endtask : tick
   task ends(input string nm);
      $display("test %s done", nm);
   endtask : ends
   // Bounded wait for a level; running out ends the run as a failure
   task automatic wait_hi(ref logic s, input int lim, output int c);
      c = 0;
      while (s !== 1'b1) begin
         if (c >= lim) begin
            chk("wait bound", 0, 1);
            summarize();
         end
         @(posedge pclk);
         c++;
      end
   endtask : wait_hi
   task want(input logic [9:0] e, input logic [9:0] m = 10'h3FF);
      out_q.push_back({m, e});
   endtask : want
   // One APB transfer; an idle edge first, so psel is never assigned twice in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [32:0] e);
      int c;
      c = 0;
      @(posedge pclk);
      if (!wr) rd_q.push_back(e);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         c++;
      end while (pready !== 1'b1 && c < 20);
      if (c >= 20) begin
         chk("pready bound", 0, 1);
         summarize();
      end
      psel <= 0;
      penable <= 0;
   endtask : apb
   // Read data is taken at the edge where the access completes
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) chk("apb read", rd_q.pop_front(), {pslverr, prdata});
   end
   // Output notes are compared once the edge's updates have settled
   always @(negedge pclk) begin
      while (out_q.size() > 0) begin
         w = out_q.pop_front();
         chk("outputs", {23'h0, w[9:0] & w[19:10]}, {23'h0, w[19:10] & {pump_enable,
            pump_output_connect, flash_level_select, timeout_active, pump_gain, sink_enable}});
      end
   end
   initial begin
      tick(16);
      presetn <= 1;
      apb(0, 12'h000, 0, {1'b0, 32'h0000_0001});
      apb(0, 12'h004, 0, 33'h0);
      apb(0, 12'h008, 0, {1'b1, 32'h0});
      repeat (3) lfsr = lfsr_next(lfsr);
      step = {3'b001, lfsr[4:0]};
      apb(1, 12'h000, {24'h0, step}, 33'h0);
      apb(0, 12'h000, 0, {9'h0, 16'h0, step});
      ends("registers");
      // Other pins high while disabled change nothing
      flash_req <= 1;
      sel_req <= 1;
      tx_len <= 8'h10;
      tx_start <= 1;
      tick(1);
      tx_start <= 0;
      tick(6);
      want(10'h000);
      flash_req <= 0;
      tick(20);
      ends("shutdown");
      // Start-up: ramp, then sinks only after regulation
      en_req <= 1;
      wait_hi(ref_on, 100, n);
      chk("first ramp step", {25'h0, step}, {25'h0, reference_level});
      tick(400);
      want(10'h300);
      output_in_regulation <= 1;
      wait_hi(sinks_on, 20, n);
      tick(1);
      want(10'h307);
      sel_req <= 0;
      tick(5);
      want(10'h30F);
      ends("startup");
      // Flash level, then a transmit pulse pulls it back to torch
      flash_req <= 1;
      tick(5);
      want(10'h38F);
      tx_len <= 8'd20;
      tx_start <= 1;
      tick(1);
      tx_start <= 0;
      tick(6);
      want(10'h30F);
      tick(22);
      want(10'h38F);
      ends("transmit hold");
      // A short loss of headroom must not step the gain
      gain_tgt = 2'd1;
      sink_out_of_regulation <= 1;
      tick(5);
      sink_out_of_regulation <= 0;
      tick(20);
      want(10'h38F);
      sink_out_of_regulation <= 1;
      wait_hi(gain_hit, 100, n);
      chk("flash step time", 1, n >= FS && n <= FS + 6);
      sink_out_of_regulation <= 0;
      tick(5);
      want(10'h39F);
      flash_req <= 0;
      gain_tgt = 2'd2;
      tick(5);
      sink_out_of_regulation <= 1;
      wait_hi(gain_hit, 200, n);
      chk("torch step time", 1, n >= TS && n <= TS + 6);
      tick(TS + 10);
      want(10'h32F);
      sink_out_of_regulation <= 0;
      tick(3);
      ends("gain");
      // Timer frozen while the hold is up, then runs out
      tx_len <= 8'd250;
      tx_start <= 1;
      tick(1);
      tx_start <= 0;
      tick(3);
      flash_req <= 1;
      tick(240);
      want(10'h32F);
      wait_hi(timeout_active, 400, n);
      chk("timeout time", 1, n >= TO && n <= TO + 20);
      tick(2);
      want(10'h360, 10'h37F);
      flash_req <= 0;
      tick(10);
      want(10'h360, 10'h37F);
      ends("timeout");
      // Shutdown clears gain and timeout; re-enable resumes at 1x
      en_req <= 0;
      // Gain code clears one edge after the other outputs, so allow six edges
      tick(6);
      want(10'h000);
      apb(0, 12'h004, 0, 33'h0);
      en_req <= 1;
      wait_hi(sinks_on, 400, n);
      tick(1);
      want(10'h30F);
      tick(5);
      ends("re-enable");
      summarize();
   end
endmodule : flash_led_pump_mode_control_tb
